// ===== logic/rcr_reset_cause_recorder.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Release reset after power-on and power-up delays, not waiting for oscillator.
// - Monitor on: clock not ready after delays raises clock-fail trap at 0x000004.
// - On that trap switch system clock to internal fast RC oscillator.
// - Monitor and power-up timer off: skip the timer, go to clock wait after power-on delay.
// - Monitor off and no clock: hold at reset vector until clock appears.
// - Power-on: PC zero, set power-on flag, clear all others.
// - Pin reset running: PC zero, set pin flag, clear soft, watchdog, idle, sleep.
// - Soft reset: PC zero, set soft flag, clear pin, watchdog, idle, sleep.
// - Pin reset in sleep: PC zero, set pin and sleep, clear watchdog, idle.
// - Pin reset in idle: PC zero, set pin and idle, clear watchdog, sleep.
// - Watchdog running resets to zero; in sleep resumes PC+2 setting watchdog, sleep.
// - Interrupt wake from sleep: set sleep flag, PC takes interrupt vector.
// - Trap-conflict or illegal-op reset: PC zero, set own flag only.
// - Cause flags software read/write; untouched flags keep software value.
// - Watchdog runs from its own RC clock, surviving main clock failure.
// - Clock failure sets clock-fail status bit 3 of oscillator control.
// - Power-up delay selectable 0, 4, 16 or 64 ms.
module rcr_reset_cause_recorder
    import rcr_pkg::*;
#(
    parameter int PWRT1   = rcr_pkg::PWRT1_CYC,
    parameter int PWRT2   = rcr_pkg::PWRT2_CYC,
    parameter int PWRT3   = rcr_pkg::PWRT3_CYC,
    parameter int WDT_W   = 16
) (
    // Clocks and reset
    input  wire logic                        clock,
    input  wire logic                        arst_n,
    input  wire logic                        wdtClock,
    // Configuration straps
    input  wire logic                        clockFailMonitorEn,
    input  wire logic [1:0]                  powerUpDelaySel,
    input  wire logic                        watchdogEn,
    // Oscillator readiness
    input  wire logic                        oscRunning,
    input  wire logic                        oscStartTimerDone,
    input  wire logic                        pllLocked,
    input  wire logic                        usePll,
    input  wire logic                        sysClockPresent,
    // Core events (one-cycle pulses) and core state levels
    input  wire logic                        masterClearPin,
    input  wire logic                        softResetReq,
    input  wire logic                        trapConflict,
    input  wire logic                        illegalOp,
    input  wire logic                        watchdogKick,
    input  wire logic                        irqWake,
    input  wire logic [rcr_pkg::PC_W-1:0]    irqVector,
    input  wire logic                        inSleep,
    input  wire logic                        inIdle,
    input  wire logic [rcr_pkg::PC_W-1:0]    curPc,
    // Core control
    output logic                             coreReset,
    output logic                             pcLoad,
    output logic [rcr_pkg::PC_W-1:0]         pcValue,
    output logic                             useFastRc,
    // Avalon-MM slave
    input  wire logic [rcr_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [rcr_pkg::DATA_W-1:0]  avs_writedata,
    output logic [rcr_pkg::DATA_W-1:0]       avs_readdata,
    output logic                             avs_waitrequest,
    // Interrupt
    output logic                             irq
);
    import rcr_pkg::*;

    rcr_state_t       state_r;
    logic [31:0]      delay_r;
    logic [CAUSE_W-1:0] cause_r;
    logic [CAUSE_W-1:0] cause_nxt;
    logic             clkFail_r;
    logic             frcSel_r;
    logic [IRQ_W-1:0] irqSt_r;
    logic [IRQ_W-1:0] irqMsk_r;
    logic [IRQ_W-1:0] irqEv;
    logic             ack_r;
    logic             wdtExp;
    logic [1:0]       wdtSync_r;
    logic             wdtSeen_r;
    logic             wdtEvent;
    logic             clockReady;
    logic             delayDone;
    logic             anyReset;
    logic             wrCause;

    function automatic logic [31:0] pwrtCycles(input logic [1:0] sel);
        case (sel)
            2'h1:    pwrtCycles = PWRT1;
            2'h2:    pwrtCycles = PWRT2;
            2'h3:    pwrtCycles = PWRT3;
            default: pwrtCycles = 32'h0;
        endcase
    endfunction

    rcr_watchdog #(.CNT_W(WDT_W)) uWdt (
        .rcClock (wdtClock),
        .arst_n  (arst_n),
        .enable  (watchdogEn),
        .kick    (watchdogKick),
        .top     (WDT_W'(WDT_DEF_TOP)),
        .expired (wdtExp)
    );

    // Bring watchdog expiry level into the main domain and detect rise
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wdtSync_r <= 2'h0;
            wdtSeen_r <= 1'b0;
        end else begin
            wdtSync_r <= {wdtSync_r[0], wdtExp};
            wdtSeen_r <= wdtSync_r[1];
        end
    end
    assign wdtEvent = wdtSync_r[1] & ~wdtSeen_r;

    assign clockReady = oscRunning && oscStartTimerDone && (!usePll || pllLocked);
    assign delayDone  = (delay_r == 32'h0);
    assign anyReset   = masterClearPin || softResetReq || trapConflict || illegalOp
                        || (wdtEvent && !inSleep);

    // Power-up sequencing
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= RCR_POR;
            delay_r <= 32'(POR_CYC);
        end else begin
            case (state_r)
                RCR_POR: begin
                    if (!delayDone) begin
                        delay_r <= delay_r - 32'h1;
                    end else if (pwrtCycles(powerUpDelaySel) == 32'h0 && !clockFailMonitorEn) begin
                        state_r <= RCR_WAIT;
                    end else begin
                        delay_r <= pwrtCycles(powerUpDelaySel);
                        state_r <= RCR_POWER_UP_DELAY_TIMER;
                    end
                end
                RCR_POWER_UP_DELAY_TIMER: begin
                    if (!delayDone) begin
                        delay_r <= delay_r - 32'h1;
                    end else begin
                        state_r <= RCR_WAIT;
                    end
                end
                RCR_WAIT: begin
                    if (clockFailMonitorEn || sysClockPresent) begin
                        state_r <= RCR_RUN;
                    end
                end
                RCR_RUN: begin
                    state_r <= RCR_RUN;
                end
                default: begin
                    state_r <= RCR_POR;
                    delay_r <= 32'(POR_CYC);
                end
            endcase
        end
    end

    // Core held in reset until release, no wait on oscillator
    assign coreReset = (state_r != RCR_RUN);

    wire startFail = (state_r == RCR_WAIT) && clockFailMonitorEn && !clockReady;
    wire runFail   = (state_r == RCR_RUN) && clockFailMonitorEn && !clockReady && !frcSel_r;
    wire clkFailEv = startFail || runFail;
    wire release_  = (state_r == RCR_WAIT) && (clockFailMonitorEn || sysClockPresent);

    // Program counter load
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pcLoad  <= 1'b0;
            pcValue <= VEC_RESET;
        end else begin
            pcLoad <= 1'b0;
            if (clkFailEv) begin
                pcLoad  <= 1'b1;
                pcValue <= VEC_CFAIL;
            end else if (release_) begin
                pcLoad  <= 1'b1;
                pcValue <= VEC_RESET;
            end else if (state_r == RCR_RUN && anyReset) begin
                pcLoad  <= 1'b1;
                pcValue <= VEC_RESET;
            end else if (state_r == RCR_RUN && wdtEvent && inSleep) begin
                pcLoad  <= 1'b1;
                pcValue <= curPc + PC_STEP;
            end else if (state_r == RCR_RUN && irqWake && inSleep) begin
                pcLoad  <= 1'b1;
                pcValue <= irqVector;
            end
        end
    end

    // Clock-fail status and fast RC selection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clkFail_r <= 1'b0;
            frcSel_r  <= 1'b0;
        end else begin
            if (clkFailEv) begin
                clkFail_r <= 1'b1;
                frcSel_r  <= 1'b1;
            end else if (avs_write && ack_r && avs_address == OFF_OSC) begin
                clkFail_r <= avs_writedata[O_CF];
                frcSel_r  <= avs_writedata[O_FRC];
            end
        end
    end
    assign useFastRc = frcSel_r;

    assign wrCause = avs_write && ack_r && avs_address == OFF_CAUSE;

    // Cause flag update; hardware events override a same-cycle software write
    always_comb begin
        cause_nxt = wrCause ? avs_writedata[CAUSE_W-1:0] : cause_r;
        if (state_r == RCR_RUN && !clkFailEv) begin
            if (masterClearPin) begin
                cause_nxt[F_PIN]   = 1'b1;
                cause_nxt[F_WDT]   = 1'b0;
                cause_nxt[F_IDLE]  = inIdle && !inSleep;
                cause_nxt[F_SLEEP] = inSleep;
                if (!inSleep && !inIdle) begin
                    cause_nxt[F_SOFT] = 1'b0;
                end
            end else if (softResetReq) begin
                cause_nxt[F_SOFT]  = 1'b1;
                cause_nxt[F_PIN]   = 1'b0;
                cause_nxt[F_WDT]   = 1'b0;
                cause_nxt[F_IDLE]  = 1'b0;
                cause_nxt[F_SLEEP] = 1'b0;
            end else if (trapConflict) begin
                cause_nxt[F_TRAP] = 1'b1;
            end else if (illegalOp) begin
                cause_nxt[F_ILL] = 1'b1;
            end else if (wdtEvent) begin
                cause_nxt[F_WDT] = 1'b1;
                if (inSleep) begin
                    cause_nxt[F_SLEEP] = 1'b1;
                end else begin
                    cause_nxt[F_PIN]   = 1'b0;
                    cause_nxt[F_SOFT]  = 1'b0;
                    cause_nxt[F_IDLE]  = 1'b0;
                    cause_nxt[F_SLEEP] = 1'b0;
                end
            end else if (irqWake && inSleep) begin
                cause_nxt[F_SLEEP] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cause_r <= CAUSE_W'(1 << F_POR);
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    assign irqEv[I_CFAIL] = clkFailEv;
    assign irqEv[I_RESET] = (state_r == RCR_RUN) && anyReset;
    assign irqEv[I_WAKE]  = (state_r == RCR_RUN) && inSleep && (irqWake || wdtEvent);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irqSt_r  <= '0;
            irqMsk_r <= '0;
        end else begin
            if (avs_write && ack_r && avs_address == OFF_IRQST) begin
                irqSt_r <= (irqSt_r & ~avs_writedata[IRQ_W-1:0]) | irqEv;
            end else begin
                irqSt_r <= irqSt_r | irqEv;
            end
            if (avs_write && ack_r && avs_address == OFF_IRQMSK) begin
                irqMsk_r <= avs_writedata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irqSt_r & irqMsk_r);

    // Avalon slave: one wait cycle, answer on the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_r) begin
            case (avs_address)
                OFF_CAUSE:  avs_readdata <= DATA_W'(cause_r);
                OFF_OSC:    avs_readdata <= DATA_W'({clkFail_r, 2'h0, frcSel_r});
                OFF_IRQST:  avs_readdata <= DATA_W'(irqSt_r);
                OFF_IRQMSK: avs_readdata <= DATA_W'(irqMsk_r);
                default:    avs_readdata <= '0;
            endcase
        end
    end
endmodule // rcr_reset_cause_recorder
`default_nettype wire

// ===== logic/rcr_pkg.sv
package rcr_pkg;
    // Bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int PC_W   = 24;

    // Register byte offsets
    localparam logic [3:0] OFF_CAUSE  = 4'h0;
    localparam logic [3:0] OFF_OSC    = 4'h4;
    localparam logic [3:0] OFF_IRQST  = 4'h8;
    localparam logic [3:0] OFF_IRQMSK = 4'hc;

    // Reset cause register fields
    localparam int F_POR   = 0;
    localparam int F_PIN   = 1;
    localparam int F_SOFT  = 2;
    localparam int F_WDT   = 3;
    localparam int F_IDLE  = 4;
    localparam int F_SLEEP = 5;
    localparam int F_TRAP  = 6;
    localparam int F_ILL   = 7;
    localparam int CAUSE_W = 8;

    // Oscillator control fields
    localparam int O_FRC = 0;
    localparam int O_CF  = 3;

    // Interrupt status fields
    localparam int I_CFAIL = 0;
    localparam int I_RESET = 1;
    localparam int I_WAKE  = 2;
    localparam int IRQ_W   = 3;

    // Vectors
    localparam logic [23:0] VEC_RESET = 24'h000000;
    localparam logic [23:0] VEC_CFAIL = 24'h000004;
    localparam logic [23:0] PC_STEP   = 24'h000002;

    // Timing
    localparam int CLK_HZ       = 10000000;
    localparam int T_POR_US     = 10;
    localparam int POR_CYC      = (T_POR_US * (CLK_HZ / 1000000) > 0) ? T_POR_US * (CLK_HZ / 1000000) : 1;
    localparam int T_PWRT1_MS   = 4;
    localparam int T_PWRT2_MS   = 16;
    localparam int T_PWRT3_MS   = 64;
    localparam int PWRT1_CYC    = T_PWRT1_MS * (CLK_HZ / 1000);
    localparam int PWRT2_CYC    = T_PWRT2_MS * (CLK_HZ / 1000);
    localparam int PWRT3_CYC    = T_PWRT3_MS * (CLK_HZ / 1000);
    localparam int WDT_DEF_TOP  = 16'hffff;

    typedef enum logic [3:0] {
        RCR_POR  = 4'b0001,
        RCR_POWER_UP_DELAY_TIMER = 4'b0010,
        RCR_WAIT = 4'b0100,
        RCR_RUN  = 4'b1000
    } rcr_state_t;
endpackage : rcr_pkg

// ===== logic/rcr_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_watchdog #(
    parameter int CNT_W = 16
) (
    // Dedicated RC clock domain
    input  wire logic             rcClock,
    input  wire logic             arst_n,
    // Control, already synchronous to rcClock
    input  wire logic             enable,
    input  wire logic             kick,
    input  wire logic [CNT_W-1:0] top,
    // Expiry level, held until kicked or disabled
    output logic                  expired
);
    logic [CNT_W-1:0] count_r;

    // Free-runs on its own oscillator, independent of the main clock
    always_ff @(posedge rcClock or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
            expired <= 1'b0;
        end else if (kick || !enable) begin
            count_r <= '0;
            expired <= 1'b0;
        end else if (count_r == top) begin
            expired <= 1'b1;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end
endmodule // rcr_watchdog
`default_nettype wire

// ===== bench/rcr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_properties
    import rcr_pkg::*;
#(
    parameter int PWRT1 = PWRT1_CYC,
    parameter int PWRT2 = PWRT2_CYC,
    parameter int PWRT3 = PWRT3_CYC
) (
    // Clock and reset
    input wire logic                     clock,
    input wire logic                     arst_n,
    // Straps and core events
    input wire logic                     clockFailMonitorEn,
    input wire logic [1:0]               powerUpDelaySel,
    input wire logic                     sysClockPresent,
    input wire logic                     masterClearPin,
    input wire logic                     softResetReq,
    input wire logic                     trapConflict,
    input wire logic                     illegalOp,
    input wire logic                     irqWake,
    input wire logic                     inSleep,
    input wire logic [rcr_pkg::PC_W-1:0] irqVector,
    // Core control
    input wire logic                     coreReset,
    input wire logic                     pcLoad,
    input wire logic [rcr_pkg::PC_W-1:0] pcValue,
    input wire logic                     useFastRc,
    // Bus
    input wire logic                     avs_read,
    input wire logic                     avs_write,
    input wire logic                     avs_waitrequest
);
    logic [15:0] relCnt_r;
    int          dly;
    always_comb begin
        case (powerUpDelaySel)
            2'h1: dly = PWRT1;
            2'h2: dly = PWRT2;
            2'h3: dly = PWRT3;
            default: dly = 0;
        endcase
    end
    // Cycles since reset release, saturating
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) relCnt_r <= 16'h0000;
        else if (relCnt_r != 16'hffff) relCnt_r <= relCnt_r + 16'h0001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_BUS_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("bus access not stalled in first cycle");
    AST_BUS_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus stall longer than one cycle");
    AST_REL_EARLY: assert property ($fell(coreReset) |-> int'(relCnt_r) >= POR_CYC + dly)
        else $error("core released before delays ran out");
    AST_REL_LATE: assert property ((clockFailMonitorEn || sysClockPresent)
        && int'(relCnt_r) == POR_CYC + dly + 8 |-> !coreReset)
        else $error("core not released after delays");
    AST_HALT: assert property (!clockFailMonitorEn && !sysClockPresent && coreReset |=> coreReset)
        else $error("core left reset with no clock");
    AST_SOFT_PC: assert property (softResetReq && !coreReset |=> pcLoad && pcValue == VEC_RESET)
        else $error("soft reset did not restart at zero");
    AST_PIN_PC: assert property (masterClearPin && !coreReset |=> pcLoad && pcValue == VEC_RESET)
        else $error("pin reset did not restart at zero");
    AST_TRAP_PC: assert property ((trapConflict || illegalOp) && !coreReset
        |=> pcLoad && pcValue == VEC_RESET)
        else $error("trap reset did not restart at zero");
    AST_WAKE_PC: assert property (irqWake && inSleep && !coreReset
        |=> pcLoad && pcValue == $past(irqVector))
        else $error("wake did not load interrupt vector");
    AST_CFAIL_FRC: assert property (pcLoad && pcValue == VEC_CFAIL |-> ##[0:1] useFastRc)
        else $error("clock fail trap without fast RC");
endmodule // rcr_properties

bind rcr_reset_cause_recorder rcr_properties #(.PWRT1(PWRT1), .PWRT2(PWRT2), .PWRT3(PWRT3)) u_props (
    .clock, .arst_n, .clockFailMonitorEn, .powerUpDelaySel, .sysClockPresent, .masterClearPin,
    .softResetReq, .trapConflict, .illegalOp, .irqWake, .inSleep, .irqVector, .coreReset, .pcLoad,
    .pcValue, .useFastRc, .avs_read, .avs_write, .avs_waitrequest
);
`default_nettype wire

// ===== bench/rcr_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rcr_pkg::*;
    localparam int P1 = 10;
    localparam int P2 = 20;
    localparam int P3 = 30;
    logic        clock = 1'b0;
    logic        wdtClock = 1'b0;
    logic        arst_n = 1'b0;
    logic        mon, pinP, softP, trapP, illP, kick, wake, slp, idl, wdEn, oscR, usePll, sysClk, aRd, aWr;
    logic [1:0]  sel;
    logic [23:0] vec, cur, pcValue;
    logic [3:0]  aAddr;
    logic [31:0] aWd, rdata, q;
    logic        coreReset, pcLoad, useFastRc, waitReq, irq;
    int          error_cnt = 0;
    int          compares = 0;
    int          c;
    always #50 clock = ~clock;
    always #37 wdtClock = ~wdtClock;

    rcr_reset_cause_recorder #(.PWRT1(P1), .PWRT2(P2), .PWRT3(P3), .WDT_W(6)) u_dut (
        .clock(clock), .arst_n(arst_n), .wdtClock(wdtClock), .clockFailMonitorEn(mon),
        .powerUpDelaySel(sel), .watchdogEn(wdEn), .oscRunning(oscR), .oscStartTimerDone(oscR),
        .pllLocked(1'b1), .usePll(usePll), .sysClockPresent(sysClk), .masterClearPin(pinP),
        .softResetReq(softP), .trapConflict(trapP), .illegalOp(illP), .watchdogKick(kick),
        .irqWake(wake), .irqVector(vec), .inSleep(slp), .inIdle(idl), .curPc(cur),
        .coreReset(coreReset), .pcLoad(pcLoad), .pcValue(pcValue), .useFastRc(useFastRc),
        .avs_address(aAddr), .avs_read(aRd), .avs_write(aWr), .avs_writedata(aWd),
        .avs_readdata(rdata), .avs_waitrequest(waitReq), .irq(irq)
    );

    task automatic conclude;
        $display("compares=%0d errors=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_b(input logic e, input logic g);
        chk_w({31'h0, e}, {31'h0, g});
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        aRd <= !w;
        aWr <= w;
        aAddr <= a;
        aWd <= d;
        do begin
            @(negedge clock);
            n++;
        end while (waitReq !== 1'b0 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            conclude();
        end
        // Request held to the edge that sees waitrequest low; data taken there
        @(posedge clock);
        q = rdata;
        aRd <= 1'b0;
        aWr <= 1'b0;
        // Let register updates settle before callers look at outputs
        @(negedge clock);
    endtask
    task automatic waitRel(input int lim);
        c = 0;
        while (coreReset !== 1'b0 && c < lim) begin
            @(negedge clock);
            c++;
        end
    endtask
    task automatic doReset(input logic [1:0] s, input logic m, input logic o, input logic p);
        @(posedge clock);
        arst_n <= 1'b0;
        sel <= s;
        mon <= m;
        oscR <= o;
        sysClk <= p;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
    endtask
    function automatic int dlyOf(input int s);
        return (s == 1) ? P1 : (s == 2) ? P2 : (s == 3) ? P3 : 0;
    endfunction
    // Event kinds: 0 pin, 1 soft, 2 pin in sleep, 3 pin in idle, 4 trap, 5 illegal, 6 wake, 7 wdt, 8 wdt in sleep
    function automatic logic [7:0] expCause(input int k, input logic [7:0] o);
        case (k)
            0: return (o & 8'hc3) | 8'h02;
            1: return (o & 8'hc5) | 8'h04;
            2: return (o & 8'he7) | 8'h22;
            3: return (o & 8'hd7) | 8'h12;
            4: return o | 8'h40;
            5: return o | 8'h80;
            6: return o | 8'h20;
            7: return (o & 8'hc9) | 8'h08;
            default: return o | 8'h28;
        endcase
    endfunction
    task automatic evt(input int k);
        logic [7:0]  o;
        logic [23:0] ep;
        int          n;
        o = 8'($urandom());
        bus(1'b1, OFF_CAUSE, {24'h0, o});
        bus(1'b0, OFF_CAUSE, 32'h0);
        chk_w({24'h0, o}, q);
        @(posedge clock);
        cur <= 24'($urandom()) | 24'h000100;
        vec <= 24'($urandom()) | 24'h000100;
        slp <= (k == 2 || k == 6 || k == 8);
        idl <= (k == 3);
        @(posedge clock);
        pinP <= (k == 0 || k == 2 || k == 3);
        softP <= (k == 1);
        trapP <= (k == 4);
        illP <= (k == 5);
        wake <= (k == 6);
        wdEn <= (k >= 7);
        kick <= (k < 7);
        @(posedge clock);
        {pinP, softP, trapP, illP, wake} <= 5'h00;
        ep = (k == 8) ? cur + PC_STEP : (k == 6) ? vec : VEC_RESET;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (pcLoad !== 1'b1 && n < ((k >= 7) ? 3000 : 1));
        chk_b(1'b1, pcLoad);
        chk_w({8'h0, ep}, {8'h0, pcValue});
        @(posedge clock);
        {slp, idl, wdEn, kick} <= 4'h1;
        waitRel(400);
        bus(1'b0, OFF_CAUSE, 32'h0);
        chk_w({24'h0, expCause(k, o)}, q);
        $display("event %0d done", k);
    endtask

    initial begin
        {mon, pinP, softP, trapP, illP, wake, slp, idl, wdEn, aRd, aWr} = 11'h000;
        {kick, oscR, sysClk} = 3'h7;
        sel = 2'h0;
        vec = 24'h000100;
        cur = 24'h000100;
        aAddr = 4'h0;
        aWd = 32'h0;
        c = $urandom(32'hd87ddca6);
        usePll = 1'($urandom());
        for (int s = 0; s < 4; s++) begin
            doReset(2'(s), s != 0, s != 3, 1'b1);
            waitRel(400);
            chk_b(1'b1, c >= POR_CYC + dlyOf(s) && c <= POR_CYC + dlyOf(s) + 8);
            repeat (4) @(posedge clock);
            bus(1'b0, OFF_CAUSE, 32'h0);
            chk_w(32'h00000001, q);
            chk_w({8'h0, (s == 3) ? VEC_CFAIL : VEC_RESET}, {8'h0, pcValue});
            bus(1'b0, OFF_OSC, 32'h0);
            chk_b(s == 3, q[O_CF]);
            chk_b(s == 3, useFastRc);
            $display("release test %0d done", s);
        end
        doReset(2'h0, 1'b0, 1'b1, 1'b0);
        waitRel(300);
        chk_b(1'b1, coreReset);
        chk_w({8'h0, VEC_RESET}, {8'h0, pcValue});
        @(posedge clock);
        sysClk <= 1'b1;
        waitRel(20);
        chk_b(1'b0, coreReset);
        bus(1'b1, 4'h6, $urandom());
        bus(1'b0, 4'h6, 32'h0);
        chk_w(32'h0, q);
        $display("halt and unmapped test done");
        for (int k = 0; k < 9; k++) evt(k);
        repeat (6) evt($urandom_range(0, 8));
        bus(1'b1, OFF_IRQMSK, 32'h0);
        bus(1'b1, OFF_IRQST, 32'h7);
        evt(6);
        bus(1'b0, OFF_IRQST, 32'h0);
        chk_w(32'h4, q);
        chk_b(1'b0, irq);
        bus(1'b1, OFF_IRQMSK, 32'h4);
        chk_b(1'b1, irq);
        bus(1'b1, OFF_IRQST, 32'h4);
        bus(1'b0, OFF_IRQST, 32'h0);
        chk_w(32'h0, q);
        chk_b(1'b0, irq);
        $display("interrupt test done");
        conclude();
    end
endmodule // testbench
`default_nettype wire
